// file: rtl/trxcfg_top.v
// serial command interpreter for transceiver configuration
`timescale 1ns/1ps
`include "trxcfg_defines.vh"
module trxcfg_top #(
    parameter FAST_PRE_BITS = `TRXCFG_FAST_PRE_BITS,
    parameter SLOW_PRE_BITS = `TRXCFG_SLOW_PRE_BITS
) (
    // clock and synchronous reset
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    // serial link from the host, asynchronous to i_ref_clk
    input  wire        i_chip_select_n,
    input  wire        i_sck,
    input  wire        i_sdi,
    // receive path inputs and the modulator's byte request, already on i_ref_clk
    input  wire [6:0]  i_strength_dbm_neg,
    input  wire        i_bit_tick,
    input  wire        i_tx_byte_ready,
    // transmit side
    output reg         o_sdo,
    output reg  [7:0]  o_tx_byte,
    output reg         o_tx_valid,
    // decoded settings, held until overwritten, and the strength flag recomputed every cycle
    output reg  [11:0] o_channel,
    output reg         o_pin16_role_sel,
    output reg  [1:0]  o_valid_detect_speed,
    output reg  [2:0]  o_rx_bandwidth_sel,
    output reg  [1:0]  o_lna_attenuation,
    output reg  [2:0]  o_strength_threshold,
    output reg         o_strength_over,
    output reg         o_digital_filter_select,
    output reg  [2:0]  o_quality_threshold,
    // clock recovery state
    output reg         o_fast_lock_active,
    output reg         o_clock_locked
);
    // synchronised pins
    wire       cs_n_s;      // select, synchronised
    wire       sck_s;       // serial clock, synchronised
    wire       sdi_s;       // serial data, synchronised
    // edge detection
    reg        sck_d;       // previous serial clock for edge find
    reg        cs_d;        // previous select
    wire       sck_rise;    // rising edge of serial clock
    wire       cs_fall;     // select falling edge
    // word assembly and framing
    reg [15:0] shift;       // incoming bits
    reg [4:0]  bit_cnt;     // bits in current word
    reg        stream_tx;   // sequential transmit mode
    // stored command words
    reg [15:0] rx_ctl;      // receiver control word
    reg [15:0] freq_set;    // carrier frequency word
    reg [15:0] digital_filter_select_ctl;    // baseband filter word
    // transmit byte path
    reg        wr_byte;     // a transmit byte arrived
    reg [7:0]  wr_data;     // that byte
    wire       buf_ready;   // buffer can take a byte
    wire [7:0] buf_data;    // head of buffer
    wire       buf_valid;   // buffer holds a byte
    reg        pre_loaded;  // reset preamble byte still pending
    // clock recovery and strength compare
    reg [4:0]  pre_cnt;     // preamble bits seen by clock recovery
    wire [15:0] word_in;    // word including current bit
    reg [7:0]  next_thr;    // effective threshold magnitude

    // select idles high, so its stages reset high and no false fall follows
    trxcfg_sync #(.INIT(1'b1)) u_cs (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_chip_select_n),
        .o_sync    (cs_n_s)
    );
    // serial clock rests low, so no false rise follows reset
    trxcfg_sync #(.INIT(1'b0)) u_sck (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_sck),
        .o_sync    (sck_s)
    );
    // data bit, same latency as the serial clock so the two stay aligned
    trxcfg_sync #(.INIT(1'b0)) u_sdi (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_sdi),
        .o_sync    (sdi_s)
    );

    // transmit byte buffer, drained by the modulator
    // it hands a byte over only when the output stage is empty
    trxcfg_buf2 #(.WIDTH(8)) u_buf (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_data    (wr_data),
        .i_valid   (wr_byte),
        .o_ready   (buf_ready),
        .o_data    (buf_data),
        .o_valid   (buf_valid),
        .i_ready   (i_tx_byte_ready && !pre_loaded && !o_tx_valid)
    );

    // one-cycle strobes from the synchronised levels
    assign sck_rise = sck_s && !sck_d;
    assign cs_fall  = cs_d && !cs_n_s;
    assign word_in  = {shift[14:0], sdi_s};

    // channel range check
    function chan_ok;
        input [11:0] ch;
        begin
            // both end points are legal channels
            chan_ok = (ch >= `TRXCFG_CHAN_MIN) && (ch <= `TRXCFG_CHAN_MAX);
        end
    endfunction

    // lna attenuation magnitude in dB
    function [7:0] atten_db;
        input [1:0] g;
        begin
            // codes 00 to 11 give 0, 6, 14 and 20 dB
            case (g)
                2'b00:   atten_db = 8'd0;
                2'b01:   atten_db = 8'd6;
                2'b10:   atten_db = 8'd14;
                default: atten_db = 8'd20;
            endcase
        end
    endfunction

    // edge history
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            // match the idle levels of the pins
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d  <= cs_n_s;
        end
    end

    // serial shifter and command decode
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            // idle framing, default words in the registers
            shift     <= 16'h0000;
            bit_cnt   <= 5'd0;
            stream_tx <= 1'b0;
            rx_ctl    <= `TRXCFG_RST_RXCTL;
            freq_set  <= `TRXCFG_RST_FREQ;
            digital_filter_select_ctl  <= `TRXCFG_RST_DIGITAL_FILTER_SELECT;
            wr_byte   <= 1'b0;
            wr_data   <= 8'h00;
        end else begin
            // write strobe lasts a single cycle
            wr_byte <= 1'b0;
            if (cs_n_s || cs_fall) begin
                // select released or freshly asserted: new framing
                bit_cnt   <= 5'd0;
                stream_tx <= 1'b0;
            end else if (sck_rise) begin
                shift <= word_in;  // msb first
                if (stream_tx && bit_cnt == 5'd7) begin
                    // each further byte goes straight to the transmit buffer, dropped if the buffer is full
                    bit_cnt <= 5'd0;
                    wr_byte <= buf_ready;
                    wr_data <= word_in[7:0];
                end else if (!stream_tx && bit_cnt == 5'd15) begin
                    // sixteenth bit completes a command word
                    bit_cnt <= 5'd16;
                    if (word_in[15:8] == `TRXCFG_CMD_TXREG) begin
                        wr_byte   <= buf_ready;
                        wr_data   <= word_in[7:0];
                        stream_tx <= 1'b1;
                        bit_cnt   <= 5'd0;
                    end else if (word_in[15:8] == `TRXCFG_CMD_DIGITAL_FILTER_SELECT) begin
                        digital_filter_select_ctl <= word_in;
                    end else if (word_in[15:11] == `TRXCFG_CMD_RXCTL) begin
                        rx_ctl <= word_in;
                    end else if (word_in[15:12] == `TRXCFG_CMD_FREQ) begin
                        // only legal channels replace the stored word
                        if (chan_ok(word_in[11:0])) begin
                            freq_set <= word_in;  // out of range kept old
                        end
                    end
                end else if (bit_cnt != 5'd16) begin
                    // count bits, then hold until select is released
                    bit_cnt <= bit_cnt + 5'd1;
                end
            end
        end
    end

    // transmit byte output and empty flag
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            // preamble byte stands ready at power-up
            o_tx_byte  <= `TRXCFG_RST_TXBYTE;  // preamble on power-up
            o_tx_valid <= 1'b1;
            pre_loaded <= 1'b1;
            o_sdo      <= 1'b0;
        end else begin
            // modulator takes the byte on show
            if (o_tx_valid && i_tx_byte_ready) begin
                o_tx_valid <= 1'b0;
                pre_loaded <= 1'b0;
            end else if (!o_tx_valid && buf_valid && i_tx_byte_ready) begin
                // refill from the buffer head
                o_tx_byte  <= buf_data;
                o_tx_valid <= 1'b1;
            end
            // high when another byte may be written
            o_sdo <= buf_ready && !(wr_byte) && !cs_n_s && stream_tx;
        end
    end

    // decoded settings and signal-strength compare
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            // field values of the default words
            o_channel               <= 12'h680;
            o_pin16_role_sel        <= 1'b0;
            o_valid_detect_speed    <= 2'b00;
            o_rx_bandwidth_sel      <= 3'b100;
            o_lna_attenuation       <= 2'b00;
            o_strength_threshold    <= 3'b000;
            o_strength_over         <= 1'b0;
            o_digital_filter_select <= 1'b0;
            o_quality_threshold     <= 3'b100;
        end else begin
            // fields copied out of the stored words
            o_channel            <= freq_set[11:0];
            o_pin16_role_sel     <= rx_ctl[`TRXCFG_RX_PIN16];
            o_valid_detect_speed <= rx_ctl[9:8];
            o_rx_bandwidth_sel   <= rx_ctl[7:5];
            o_lna_attenuation    <= rx_ctl[4:3];
            o_strength_threshold <= rx_ctl[2:0];
            // stronger than threshold means smaller magnitude
            o_strength_over <= ({1'b0, i_strength_dbm_neg} < next_thr);
            o_digital_filter_select <= digital_filter_select_ctl[`TRXCFG_DIGITAL_FILTER_SELECT_DIG];
            // quality threshold is the host's to keep in range
            o_quality_threshold     <= digital_filter_select_ctl[2:0];
        end
    end

    // effective threshold magnitude, attenuation lowers it
    always @* begin
        // magnitude: base less steps less attenuation, never below zero
        next_thr = {1'b0, `TRXCFG_STR_BASE}
                 - {1'b0, `TRXCFG_STR_STEP} * {5'd0, rx_ctl[2:0]}
                 - atten_db(rx_ctl[4:3]);
    end

    // clock recovery lock mode
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            // unlocked, slow mode, as the default filter word says
            pre_cnt            <= 5'd0;
            o_clock_locked     <= 1'b0;
            o_fast_lock_active <= 1'b0;
        end else begin
            if (digital_filter_select_ctl[`TRXCFG_DIGITAL_FILTER_SELECT_AUTO]) begin
                // fast until locked, then slow
                o_fast_lock_active <= !o_clock_locked;
            end else begin
                // manual choice of lock speed
                o_fast_lock_active <= digital_filter_select_ctl[`TRXCFG_DIGITAL_FILTER_SELECT_FAST];
            end
            // count preamble bits; a mode change mid-count cannot skip the lock
            if (i_bit_tick && !o_clock_locked) begin
                // at least the preamble length of the current mode
                if (o_fast_lock_active && pre_cnt >= FAST_PRE_BITS - 1) begin
                    o_clock_locked <= 1'b1;
                end else if (!o_fast_lock_active && pre_cnt >= SLOW_PRE_BITS - 1) begin
                    o_clock_locked <= 1'b1;
                end
                pre_cnt <= pre_cnt + 5'd1;
            end
        end
    end
endmodule

// file: include/trxcfg_defines.vh
// command codes, field positions, reset words and timing counts for the config block
`ifndef TRXCFG_DEFINES_VH
`define TRXCFG_DEFINES_VH
`define TRXCFG_CMD_TXREG      8'hb8
`define TRXCFG_CMD_DIGITAL_FILTER_SELECT       8'hc2
`define TRXCFG_CMD_RXCTL      5'h12
`define TRXCFG_CMD_FREQ       4'ha
`define TRXCFG_RST_RXCTL      16'h9080
`define TRXCFG_RST_FREQ       16'ha680
`define TRXCFG_RST_DIGITAL_FILTER_SELECT       16'hc22c
`define TRXCFG_RST_TXBYTE     8'haa
`define TRXCFG_CHAN_MIN       12'h060
`define TRXCFG_CHAN_MAX       12'hf3f
`define TRXCFG_RX_PIN16       10
`define TRXCFG_DIGITAL_FILTER_SELECT_AUTO      7
`define TRXCFG_DIGITAL_FILTER_SELECT_FAST      6
`define TRXCFG_DIGITAL_FILTER_SELECT_DIG       4
`define TRXCFG_FAST_PRE_BITS  8
`define TRXCFG_SLOW_PRE_BITS  16
`define TRXCFG_STR_BASE       7'h67
`define TRXCFG_STR_STEP       7'h06
`endif

// file: rtl/trxcfg_buf2.v
// two-entry valid/ready buffer for transmit bytes
`timescale 1ns/1ps
module trxcfg_buf2 #(
    parameter WIDTH = 8
) (
    input  wire             i_ref_clk,
    input  wire             i_rst_b,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem0;   // head entry
    reg [WIDTH-1:0] mem1;   // second entry
    reg [1:0]       count;  // entries held
    wire            push;
    wire            pop;
    assign push    = i_valid && (count != 2'd2);
    assign pop     = i_ready && (count != 2'd0);
    assign o_ready = (count != 2'd2);
    assign o_valid = (count != 2'd0);
    assign o_data  = mem0;
    // shift register style storage, read data from a register
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            count <= 2'd0;
            mem0  <= {WIDTH{1'b0}};
            mem1  <= {WIDTH{1'b0}};
        end else begin
            if (pop) begin
                mem0 <= (push && count == 2'd1) ? i_data : mem1;
            end else if (push && count == 2'd0) begin
                mem0 <= i_data;
            end
            if (push && ((count == 2'd1 && !pop) || (count == 2'd2 && pop))) begin
                mem1 <= i_data;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: rtl/trxcfg_sync.v
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module trxcfg_sync #(
    parameter INIT = 1'b0
) (
    input  wire i_ref_clk,
    input  wire i_rst_b,
    input  wire i_async,
    output reg  o_sync
);
    reg meta;  // first stage, read only by the second
    // two stage capture
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            meta   <= INIT;
            o_sync <= INIT;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// file: testbench/trxcfg_chk_asserts.sv
// port checks for the transceiver config block
`timescale 1ns/1ps
module trxcfg_chk #(
    parameter FAST_PRE_BITS = 8,
    parameter SLOW_PRE_BITS = 16
) (
    input wire        i_ref_clk,
    input wire        i_rst_b,
    input wire        i_chip_select_n,
    input wire [6:0]  i_strength_dbm_neg,
    input wire        i_bit_tick,
    input wire        i_tx_byte_ready,
    input wire [7:0]  o_tx_byte,
    input wire        o_tx_valid,
    input wire [11:0] o_channel,
    input wire [1:0]  o_lna_attenuation,
    input wire [2:0]  o_strength_threshold,
    input wire        o_strength_over,
    input wire        o_digital_filter_select,
    input wire [2:0]  o_quality_threshold,
    input wire        o_fast_lock_active,
    input wire        o_clock_locked
);
    reg  [7:0] ticks; // preamble bits since reset
    wire [1:0] g = o_lna_attenuation;
    wire [6:0] att = g == 2'h0 ? 7'd0 : g == 2'h1 ? 7'd6 : g == 2'h2 ? 7'd14 : 7'd20;
    wire [6:0] lim = 7'd103 - 7'd6 * {4'h0, o_strength_threshold} - att; // magnitude limit
    wire       over_exp = i_strength_dbm_neg < lim;
    // saturating count of preamble bits
    always @(posedge i_ref_clk)
        if (!i_rst_b) ticks <= 8'h00;
        else if (i_bit_tick && ticks != 8'hff) ticks <= ticks + 8'h01;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence sel_idle; i_chip_select_n [*8]; endsequence
    sequence level_still;
        $stable(i_strength_dbm_neg) && $stable(g) && $stable(o_strength_threshold);
    endsequence
    a_reset_words:
    assert property ($rose(i_rst_b) |-> o_channel == 12'h680 && o_tx_byte == 8'haa
        && o_tx_valid && o_quality_threshold == 3'h4 && !o_digital_filter_select
        && !o_clock_locked) else $error("reset words wrong");
    a_channel_range:
    assert property (o_channel >= 12'h060 && o_channel <= 12'hf3f) else $error("bad channel");
    a_rx_quiet:
    assert property (sel_idle |=> $stable(g) && $stable(o_strength_threshold))
        else $error("receiver field moved while idle");
    a_digital_filter_select_quiet:
    assert property (sel_idle |=> $stable(o_channel) && $stable(o_quality_threshold)
        && $stable(o_digital_filter_select)) else $error("setting moved while idle");
    a_strength_cmp:
    assert property (level_still ##1 level_still |-> o_strength_over == $past(over_exp))
        else $error("strength flag wrong");
    a_tx_stall:
    assert property (o_tx_valid && !i_tx_byte_ready |=> o_tx_valid && $stable(o_tx_byte))
        else $error("stalled byte lost");
    a_lock_holds:
    assert property (o_clock_locked |=> o_clock_locked) else $error("lock dropped");
    a_lock_preamble:
    assert property ($rose(o_clock_locked) |-> ticks >= FAST_PRE_BITS)
        else $error("lock too early");
    a_slow_preamble:
    assert property ($rose(o_clock_locked) && !$past(o_fast_lock_active)
        |-> ticks >= SLOW_PRE_BITS) else $error("slow lock too early");
endmodule
bind trxcfg_top trxcfg_chk #(.FAST_PRE_BITS(FAST_PRE_BITS), .SLOW_PRE_BITS(SLOW_PRE_BITS)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_chip_select_n(i_chip_select_n),
    .i_strength_dbm_neg(i_strength_dbm_neg), .i_bit_tick(i_bit_tick),
    .i_tx_byte_ready(i_tx_byte_ready), .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid),
    .o_channel(o_channel), .o_lna_attenuation(o_lna_attenuation),
    .o_strength_threshold(o_strength_threshold), .o_strength_over(o_strength_over),
    .o_digital_filter_select(o_digital_filter_select),
    .o_quality_threshold(o_quality_threshold), .o_fast_lock_active(o_fast_lock_active),
    .o_clock_locked(o_clock_locked));

// file: testbench/trxcfg_host.sv
// host model driving the serial command link
`timescale 1ns/1ps
module trxcfg_host (
    input  wire i_ref_clk,
    input  wire i_sdo,
    output reg  o_chip_select_n,
    output reg  o_sck,
    output reg  o_sdi
);
    localparam real HALF = 62.5; // half of the 125 ns link period
    initial begin
        o_chip_select_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    // n bits msb first, sck rests low
    task shift(input [15:0] v, input integer n);
        integer k;
        for (k = n - 1; k >= 0; k = k - 1) begin
            o_sdi = v[k];
            #HALF o_sck = 1'b1;
            #HALF o_sck = 1'b0;
        end
    endtask
    task open; begin o_chip_select_n = 1'b0; #HALF; end endtask
    // released data line flips so stale bits are not seen
    task close; begin #HALF o_chip_select_n = 1'b1; o_sdi = ~o_sdi; #300; end endtask
    task word(input [15:0] v); begin open; shift(v, 16); close; end endtask
    // bounded wait for the empty flag
    task wait_empty(output reg ok);
        integer t;
        begin
            ok = 1'b0;
            for (t = 0; t < 400 && !ok; t = t + 1) begin
                @(posedge i_ref_clk) #1 ok = i_sdo;
            end
        end
    endtask
endmodule

// file: testbench/test_trxcfg_top.sv
// self-checking bench for the transceiver config block
`timescale 1ns/1ps
module test_trxcfg_top;
    reg         i_ref_clk, i_rst_b, i_bit_tick, i_tx_byte_ready, ok;
    reg  [6:0]  i_strength_dbm_neg, lim;
    wire        cs_n, sck, sdi, o_sdo, o_tx_valid, pin, over, dig, fast, lock;
    wire [7:0]  o_tx_byte;
    wire [11:0] chan;
    wire [1:0]  spd, lna;
    wire [2:0]  bw, thr, qual;
    reg  [7:0]  exp_q[$], got_q[$], b;
    integer     err_total = 0, checks = 0, cyc = 0, n, g;
    trxcfg_host host (.i_ref_clk(i_ref_clk), .i_sdo(o_sdo), .o_chip_select_n(cs_n),
        .o_sck(sck), .o_sdi(sdi));
    trxcfg_top #(.FAST_PRE_BITS(8), .SLOW_PRE_BITS(16)) dut (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_chip_select_n(cs_n), .i_sck(sck),
        .i_sdi(sdi), .i_strength_dbm_neg(i_strength_dbm_neg), .i_bit_tick(i_bit_tick),
        .i_tx_byte_ready(i_tx_byte_ready), .o_sdo(o_sdo), .o_tx_byte(o_tx_byte),
        .o_tx_valid(o_tx_valid), .o_channel(chan), .o_pin16_role_sel(pin),
        .o_valid_detect_speed(spd), .o_rx_bandwidth_sel(bw), .o_lna_attenuation(lna),
        .o_strength_threshold(thr), .o_strength_over(over), .o_digital_filter_select(dig),
        .o_quality_threshold(qual), .o_fast_lock_active(fast), .o_clock_locked(lock));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task chk(input [31:0] nm, input [15:0] seen, input [15:0] want);
        begin
            checks = checks + 1;
            if (seen !== want) begin
                err_total = err_total + 1;
                $display("FAIL %0s expected %h seen %h", nm, want, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task clks(input integer k); begin repeat (k) @(posedge i_ref_clk); #1; end endtask
    task do_reset;
        begin
            @(posedge i_ref_clk) #1 i_rst_b = 1'b0;
            clks(10);
            i_rst_b = 1'b1;
            clks(3);
        end
    endtask
    task ticks(input integer k);
        repeat (k) begin
            @(posedge i_ref_clk) #1 i_bit_tick = 1'b1;
            @(posedge i_ref_clk) #1 i_bit_tick = 1'b0;
            clks(2);
        end
    endtask
    task wr(input [15:0] w); begin host.word(w); clks(5); end endtask
    task rx(input [15:0] w, input [10:0] e);
        begin wr(w); chk("rx", {pin, spd, bw, lna, thr}, e); end
    endtask
    task strength(input [6:0] v, input e);
        begin @(posedge i_ref_clk) #1 i_strength_dbm_neg = v; clks(4); chk("over", over, e); end
    endtask
    // byte monitor and hang guard
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (i_rst_b && o_tx_valid && i_tx_byte_ready) got_q.push_back(o_tx_byte);
        if (cyc == 20000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    initial begin
        i_rst_b = 1'b0; i_bit_tick = 1'b0; i_tx_byte_ready = 1'b0; i_strength_dbm_neg = 7'd102;
        exp_q.push_back(8'haa);
        clks(10);
        i_rst_b = 1'b1;
        clks(3);
        chk("chan", chan, 12'h680);
        chk("rx", {pin, spd, bw, lna, thr}, 11'h080);
        chk("digital_filter_select", {dig, qual}, 4'h4);
        chk("tx", {o_tx_valid, o_tx_byte}, 9'h1aa);
        chk("over", over, 1'b1);
        ticks(15); chk("lock", lock, 1'b0);
        ticks(1); clks(4); chk("lock", lock, 1'b1);
        wr(16'ha060); chk("chan", chan, 12'h060);
        wr(16'ha05f); chk("chan", chan, 12'h060);
        wr(16'haf3f); chk("chan", chan, 12'hf3f);
        wr(16'haf40); chk("chan", chan, 12'hf3f);
        rx(16'h97ff, 11'h7ff);
        rx(16'h9800, 11'h7ff);
        rx(16'h9535, 11'h535);
        // each attenuation code sets the strength limit
        for (g = 0; g < 4; g = g + 1) begin
            rx({11'h480, g[1:0], 3'h5}, {6'h00, g[1:0], 3'h5});
            lim = 7'd73 - (g == 0 ? 7'd0 : g == 1 ? 7'd6 : g == 2 ? 7'd14 : 7'd20);
            strength(lim - 7'd1, 1'b1);
            strength(lim, 1'b0);
        end
        do_reset;
        wr(16'hc27b); chk("digital_filter_select", {dig, qual}, 4'hb);
        wr(16'hc3ff); chk("digital_filter_select", {dig, qual}, 4'hb);
        ticks(7); chk("lock", lock, 1'b0);
        ticks(1); clks(4); chk("lock", {lock, fast}, 2'b11);
        do_reset;
        wr(16'hc2ab); chk("fast", fast, 1'b1);
        ticks(8); clks(4); chk("lock", {lock, fast}, 2'b10);
        // drain the preamble, then stream under a stall
        @(posedge i_ref_clk) #1 i_tx_byte_ready = 1'b1;
        clks(4);
        i_tx_byte_ready = 1'b0;
        host.open;
        host.shift(16'hb811, 16);
        exp_q.push_back(8'h11);
        ok = 1'b1;
        for (n = 1; n < 5 && ok; n = n + 1) begin
            clks(10);
            host.wait_empty(ok);
            b = {n[3:0], n[3:0]} + 8'h11;
            if (ok) host.shift({8'h00, b}, 8);
            if (ok) exp_q.push_back(b);
        end
        chk("full", ok, 1'b0);
        host.close;
        @(posedge i_ref_clk) #1 i_tx_byte_ready = 1'b1;
        clks(20);
        chk("cnt", 16'(got_q.size()), 16'(exp_q.size()));
        for (n = 0; n < exp_q.size() && n < got_q.size(); n = n + 1)
            chk("tx", got_q[n], exp_q[n]);
        wr(16'ha100); chk("chan", chan, 12'h100);
        tally_and_finish;
    end
endmodule
